/* File: hdl/pll_cfg_pkg.sv */
package pll_cfg_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_STATUS_SEL = 6'h07;
  localparam logic [5:0] IDX_FB_CTRL = 6'h16;
  localparam logic [5:0] IDX_SWALLOW = 6'h30;
  localparam logic [5:0] IDX_MAIN_CNT = 6'h31;
  localparam logic [5:0] IDX_REF_DIV = 6'h32;
  localparam logic [5:0] IDX_INPUT_CFG = 6'h33;
  localparam logic [5:0] IDX_STATE = 6'h34;

  // Field positions and widths.
  localparam int SEL_LSB = 2;
  localparam int SEL_W = 6;
  localparam int RESET_ALL_BIT = 4;
  localparam int BYPASS_BIT = 3;
  localparam int PRESC_W = 3;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_W = 13;
  localparam int REF_W = 14;
  localparam int DIFF_BIT = 0;

  // Reset values.
  localparam logic [7:0] STATUS_SEL_RST = 8'h00;
  localparam logic [7:0] FB_CTRL_RST = 8'h00;
  localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 6'h00;
  localparam logic [MAIN_W-1:0] MAIN_CNT_RST = 13'h0001;
  localparam logic [REF_W-1:0] REF_DIV_RST = 14'h0001;
  localparam logic INPUT_CFG_RST = 1'b0;

  // Bus encodings.
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Status pin selection codes.
  localparam logic [5:0] SEL_GROUND = 6'h00;
  localparam logic [5:0] SEL_FB_DIV = 6'h01;
  localparam logic [5:0] SEL_REF_DIV = 6'h02;
  localparam logic [5:0] SEL_SWALLOW = 6'h03;
  localparam logic [5:0] SEL_PRESC = 6'h04;
  localparam logic [5:0] SEL_DET_UP = 6'h05;
  localparam logic [5:0] SEL_DET_DOWN = 6'h06;
  localparam logic [5:0] SEL_MON_GROUND = 6'h20;
  localparam logic [5:0] SEL_FIRST_CLK = 6'h21;
  localparam logic [5:0] SEL_SECOND_CLK = 6'h22;
  localparam logic [5:0] SEL_USED_CLK = 6'h23;
  localparam logic [5:0] SEL_SPARE_CLK = 6'h24;
  localparam logic [5:0] SEL_USED_OK = 6'h25;
  localparam logic [5:0] SEL_SPARE_OK = 6'h26;
  localparam logic [5:0] SEL_FIRST_OK = 6'h27;
  localparam logic [5:0] SEL_SECOND_OK = 6'h28;
  localparam logic [5:0] SEL_BOTH_OK = 6'h29;
  localparam logic [5:0] SEL_LOCK_AND = 6'h2A;
  localparam logic [5:0] SEL_VCO_OK = 6'h2B;
  localparam logic [5:0] SEL_REF_IN_USE = 6'h2C;
  localparam logic [5:0] SEL_DIG_LOCK = 6'h2D;
  localparam logic [5:0] SEL_HOLDOVER = 6'h2E;
  localparam logic [5:0] SEL_LOCK_CMP = 6'h2F;
  localparam logic [5:0] SEL_SUPPLY = 6'h30;

  // Base ratio of each prescaler code.
  function automatic logic [5:0] presc_base(input logic [PRESC_W-1:0] code);
    case (code)
      3'h0: presc_base = 6'h01;
      3'h1: presc_base = 6'h02;
      3'h2: presc_base = 6'h02;
      3'h3: presc_base = 6'h04;
      3'h4: presc_base = 6'h08;
      3'h5: presc_base = 6'h10;
      3'h6: presc_base = 6'h20;
      default: presc_base = 6'h03;
    endcase
  endfunction : presc_base

  // Codes 2 to 6 are dual modulus, the rest fixed divide.
  function automatic logic presc_dual(input logic [PRESC_W-1:0] code);
    presc_dual = (code >= 3'h2) && (code <= 3'h6);
  endfunction : presc_dual

endpackage : pll_cfg_pkg

/* File: hdl/feedback_divider.sv */
`timescale 1ns/10ps
module feedback_divider
  import pll_cfg_pkg::*;
#(
  parameter int SW_W = SWALLOW_W,
  parameter int MN_W = MAIN_W
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_i,
  // Control.
  input wire logic tick_i,
  input wire logic hold_i,
  input wire logic [PRESC_W-1:0] presc_code_i,
  input wire logic bypass_i,
  input wire logic [SW_W-1:0] swallow_i,
  input wire logic [MN_W-1:0] main_i,
  // Divider pulses.
  output logic presc_pulse_o,
  output logic swallow_pulse_o,
  output logic fb_pulse_o
);
  logic [5:0] presc_cnt;
  logic [SW_W-1:0] swallow_cnt;
  logic [MN_W-1:0] main_cnt;

  // The extra count is only taken while swallowing, so a zero swallow count never adds one.
  wire dual = presc_dual(presc_code_i);
  wire [5:0] base = presc_base(presc_code_i);
  wire swallowing = dual && (swallow_cnt < swallow_i);
  wire [5:0] modulus = base + {5'h00, swallowing};
  wire presc_end = presc_cnt >= (modulus - 6'h01);
  wire bypass_eff = !dual && bypass_i;
  wire [MN_W-1:0] main_limit = (bypass_eff || main_i == '0) ? MN_W'(1) : main_i;
  wire main_end = main_cnt >= (main_limit - MN_W'(1));

  assign presc_pulse_o = tick_i && presc_end && !hold_i;
  assign fb_pulse_o = presc_pulse_o && main_end;
  assign swallow_pulse_o = presc_pulse_o && swallowing && (swallow_cnt == swallow_i - SW_W'(1));

  // Greater-or-equal ends recover cleanly when software shrinks a ratio mid-count.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      presc_cnt <= 6'h00;
      main_cnt <= '0;
      swallow_cnt <= '0;
    end else if (hold_i) begin
      presc_cnt <= 6'h00;
      main_cnt <= '0;
      swallow_cnt <= '0;
    end else if (tick_i) begin
      presc_cnt <= presc_end ? 6'h00 : presc_cnt + 6'h01;
      if (presc_pulse_o) begin
        main_cnt <= main_end ? '0 : main_cnt + MN_W'(1);
        swallow_cnt <= fb_pulse_o ? '0 : (swallowing ? swallow_cnt + SW_W'(1) : swallow_cnt);
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_fixed_bypass: assert property (
    (!dual && bypass_i && presc_pulse_o) |-> fb_pulse_o)
    else $error("bypass in fixed mode did not divide by one");

  a_dual_no_bypass: assert property (
    (dual && bypass_i && main_i > 13'h0001 && main_cnt == '0 && presc_pulse_o) |-> !fb_pulse_o)
    else $error("bypass acted in dual modulus mode");

  a_dual_plain: assert property (
    (dual && swallow_i == '0 && tick_i && !hold_i && presc_cnt == base - 6'h01)
    |-> presc_pulse_o)
    else $error("zero swallow count did not give the base ratio");

  a_dual_swallow: assert property (
    (dual && swallow_i != '0 && swallow_cnt == '0 && tick_i && presc_cnt == base - 6'h01)
    |-> !presc_pulse_o)
    else $error("swallow phase did not add one count");

  a_fixed_ratio: assert property (
    (!dual && tick_i && !hold_i && presc_cnt == base - 6'h01) |-> presc_pulse_o ##1 presc_cnt == 6'h00)
    else $error("fixed divide ratio wrong");

endmodule : feedback_divider

/* File: hdl/status_select.sv */
`timescale 1ns/10ps
module status_select
  import pll_cfg_pkg::*;
(
  // Selection.
  input wire logic [SEL_W-1:0] sel_i,
  input wire logic diff_i,
  // Toggling sources.
  input wire logic fb_div_i,
  input wire logic ref_div_i,
  input wire logic swallow_i,
  input wire logic presc_i,
  input wire logic det_up_i,
  input wire logic det_down_i,
  input wire logic first_clk_i,
  input wire logic second_clk_i,
  // Level sources.
  input wire logic ref_sel_i,
  input wire logic first_ok_i,
  input wire logic second_ok_i,
  input wire logic vco_ok_i,
  input wire logic dig_lock_i,
  input wire logic holdover_i,
  input wire logic lock_cmp_i,
  input wire logic supply_i,
  // Selected signal.
  output logic status_o
);
  // In differential mode the pair arrives on the first input and the second is absent.
  wire used_clk = (ref_sel_i && !diff_i) ? second_clk_i : first_clk_i;
  wire spare_clk = !diff_i && (ref_sel_i ? first_clk_i : second_clk_i);
  wire used_ok = (ref_sel_i && !diff_i) ? second_ok_i : first_ok_i;
  wire spare_ok = !diff_i && (ref_sel_i ? first_ok_i : second_ok_i);

  // Every code without a meaning falls to ground.
  assign status_o =
    (sel_i == SEL_FB_DIV) ? fb_div_i :
    (sel_i == SEL_REF_DIV) ? ref_div_i :
    (sel_i == SEL_SWALLOW) ? swallow_i :
    (sel_i == SEL_PRESC) ? presc_i :
    (sel_i == SEL_DET_UP) ? det_up_i :
    (sel_i == SEL_DET_DOWN) ? det_down_i :
    (sel_i == SEL_FIRST_CLK) ? first_clk_i :
    (sel_i == SEL_SECOND_CLK) ? (second_clk_i && !diff_i) :
    (sel_i == SEL_USED_CLK) ? used_clk :
    (sel_i == SEL_SPARE_CLK) ? spare_clk :
    (sel_i == SEL_USED_OK) ? used_ok :
    (sel_i == SEL_SPARE_OK) ? spare_ok :
    (sel_i == SEL_FIRST_OK) ? first_ok_i :
    (sel_i == SEL_SECOND_OK) ? second_ok_i :
    (sel_i == SEL_BOTH_OK) ? (first_ok_i && second_ok_i) :
    (sel_i == SEL_LOCK_AND) ? (dig_lock_i && used_ok && vco_ok_i) :
    (sel_i == SEL_VCO_OK) ? vco_ok_i :
    (sel_i == SEL_REF_IN_USE) ? ref_sel_i :
    (sel_i == SEL_DIG_LOCK) ? dig_lock_i :
    (sel_i == SEL_HOLDOVER) ? holdover_i :
    (sel_i == SEL_LOCK_CMP) ? lock_cmp_i :
    (sel_i == SEL_SUPPLY) ? supply_i :
    1'b0;

endmodule : status_select

/* File: hdl/pll_divider_status_select.sv */
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
// Behaviour
// - Counter bypass acts only in fixed divide mode.
// - Bypass set makes main counter divide by one.
// - Code 010 divides 2/3, or 2 without swallow.
// - Code 011 divides 4/5, or 4 without swallow.
// - Code 100 divides 8/9, or 8 without swallow.
// - Code 101 divides 16/17, or 16 otherwise.
// - Code 110 divides 32/33, or 32 otherwise.
// - Low-half selector codes without meaning give ground.
// - Codes 1-6 route divider taps and detector pulses.
// - Upper-half codes follow monitor list; 100000 grounds.
// - Code 100001 routes first or differential reference.
// - Code 100010 routes second reference, not differential.
// - Codes 100011/100100 route selected and unselected reference.
// - Codes 100101/100110 give selected and unselected status.
// - Codes 100111-101001 give frequency statuses and their AND.
// - Code 101010 gives lock AND reference AND oscillator.
// - Code 101011 gives oscillator frequency status.
// - Code 101100 shows which reference is in use.
// - Code 101101 gives digital lock flag.
// - Code 101110 gives holdover active level.
// - Code 101111 gives lock detect pin comparator.
module pll_divider_status_select
  import pll_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // AHB-Lite slave.
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HWDATA_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Clock inputs from the loop.
  input wire logic FEEDBACK_CLK_I,
  input wire logic FIRST_REFERENCE_INPUT_I,
  input wire logic SECOND_REFERENCE_INPUT_I,
  // Detector pulses.
  input wire logic PHASE_FREQ_DETECTOR_UP_I,
  input wire logic PHASE_FREQ_DETECTOR_DOWN_I,
  // Monitor levels.
  input wire logic REF_SELECT_I,
  input wire logic FIRST_REF_FREQ_OK_I,
  input wire logic SECOND_REF_FREQ_OK_I,
  input wire logic VCO_FREQ_OK_I,
  input wire logic DIGITAL_LOCK_FLAG_I,
  input wire logic HOLDOVER_I,
  input wire logic LOCK_DETECT_PIN_CMP_I,
  input wire logic PLL_SUPPLY_LEVEL_I,
  // Outputs.
  output logic STATUS_O,
  output logic FEEDBACK_DIV_O,
  output logic REF_DIV_O
);
  import pll_cfg_pkg::*;

  // Positions of the pins in the synchroniser vector.
  localparam int PIN_N = 13;
  localparam int P_FB = 0;
  localparam int P_R1 = 1;
  localparam int P_R2 = 2;
  localparam int P_UP = 3;
  localparam int P_DN = 4;
  localparam int P_RSEL = 5;
  localparam int P_R1OK = 6;
  localparam int P_R2OK = 7;
  localparam int P_VCO = 8;
  localparam int P_DLK = 9;
  localparam int P_HOLD = 10;
  localparam int P_CMP = 11;
  localparam int P_SUP = 12;

  // Software-visible state.
  logic [7:0] status_sel;
  logic [7:0] fb_ctrl;
  logic [SWALLOW_W-1:0] swallow;
  logic [MAIN_W-1:0] main_cnt;
  logic [REF_W-1:0] ref_div;
  logic diff_mode;

  // Bus data phase state.
  logic wr_pend;
  logic [5:0] wr_idx;
  logic [31:0] rd_data;

  // Pin synchronisers and edge history.
  logic [PIN_N-1:0] pin_meta;
  logic [PIN_N-1:0] pin_sync;
  logic [2:0] clk_prev;

  // Reference divider and registered taps.
  logic [REF_W-1:0] ref_cnt;
  logic fb_q;
  logic ref_q;
  logic swallow_q;
  logic presc_q;
  logic status_q;

  // Pins come from other clock domains; only the second stage is ever read.
  wire [PIN_N-1:0] pin_raw = {
    PLL_SUPPLY_LEVEL_I,
    LOCK_DETECT_PIN_CMP_I,
    HOLDOVER_I,
    DIGITAL_LOCK_FLAG_I,
    VCO_FREQ_OK_I,
    SECOND_REF_FREQ_OK_I,
    FIRST_REF_FREQ_OK_I,
    REF_SELECT_I,
    PHASE_FREQ_DETECTOR_DOWN_I,
    PHASE_FREQ_DETECTOR_UP_I,
    SECOND_REFERENCE_INPUT_I,
    FIRST_REFERENCE_INPUT_I,
    FEEDBACK_CLK_I
  };

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 3'h0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[P_R2:P_FB];
    end
  end

  // Named views of the synchronised pins.
  wire fb_s = pin_sync[P_FB];
  wire r1_s = pin_sync[P_R1];
  wire r2_s = pin_sync[P_R2];
  wire rsel_s = pin_sync[P_RSEL];
  wire r1ok_s = pin_sync[P_R1OK];
  wire r2ok_s = pin_sync[P_R2OK];
  wire vco_s = pin_sync[P_VCO];
  wire dlk_s = pin_sync[P_DLK];
  wire hold_s = pin_sync[P_HOLD];

  // Rising edges; inputs must stay below half the bus clock to be seen.
  wire fb_tick = fb_s && !clk_prev[P_FB];
  wire r1_tick = r1_s && !clk_prev[P_R1];
  wire r2_tick = r2_s && !clk_prev[P_R2];
  wire use_second = rsel_s && !diff_mode;
  wire ref_tick = use_second ? r2_tick : r1_tick;

  // Address phase decode; only whole-word accesses below 0x100 hit a register.
  wire addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
  wire addr_mapped = (HADDR_I[31:8] == 24'h0000_00) && (HSIZE_I == HSIZE_WORD);
  wire [5:0] addr_idx = HADDR_I[7:2];

  // Data phase write strobes per register.
  wire wr_sel = wr_pend && (wr_idx == IDX_STATUS_SEL);
  wire wr_fb = wr_pend && (wr_idx == IDX_FB_CTRL);
  wire wr_sw = wr_pend && (wr_idx == IDX_SWALLOW);
  wire wr_main = wr_pend && (wr_idx == IDX_MAIN_CNT);
  wire wr_ref = wr_pend && (wr_idx == IDX_REF_DIV);
  wire wr_cfg = wr_pend && (wr_idx == IDX_INPUT_CFG);

  // Next values also feed the read path, so a read right after a write sees new data.
  wire [7:0] next_status_sel = wr_sel ? HWDATA_I[7:0] : status_sel;
  wire [7:0] next_fb_ctrl = wr_fb ? {3'h0, HWDATA_I[4:0]} : fb_ctrl;
  wire [SWALLOW_W-1:0] next_swallow = wr_sw ? HWDATA_I[SWALLOW_W-1:0] : swallow;
  wire [MAIN_W-1:0] next_main_cnt = wr_main ? HWDATA_I[MAIN_W-1:0] : main_cnt;
  wire [REF_W-1:0] next_ref_div = wr_ref ? HWDATA_I[REF_W-1:0] : ref_div;
  wire next_diff_mode = wr_cfg ? HWDATA_I[DIFF_BIT] : diff_mode;

  // Live state word: pin level, differential mode and six of the monitored levels.
  wire [31:0] state_word = {24'h0000_00, hold_s, dlk_s, rsel_s, vco_s, r2ok_s, r1ok_s,
                            diff_mode, status_q};

  // Read selection; unmapped addresses read as zero.
  wire [31:0] next_rd_word =
    !addr_mapped ? 32'h0000_0000 :
    (addr_idx == IDX_STATUS_SEL) ? {24'h0000_00, next_status_sel} :
    (addr_idx == IDX_FB_CTRL) ? {24'h0000_00, next_fb_ctrl} :
    (addr_idx == IDX_SWALLOW) ? {26'h000_0000, next_swallow} :
    (addr_idx == IDX_MAIN_CNT) ? {19'h0_0000, next_main_cnt} :
    (addr_idx == IDX_REF_DIV) ? {18'h0_0000, next_ref_div} :
    (addr_idx == IDX_INPUT_CFG) ? {31'h0000_0000, next_diff_mode} :
    (addr_idx == IDX_STATE) ? state_word :
    32'h0000_0000;

  // Zero wait states, always OKAY.
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rd_data;

  // Bus phase pipeline.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      rd_data <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_phase && HWRITE_I && addr_mapped;
      wr_idx <= addr_idx;
      if (addr_phase && !HWRITE_I) begin
        rd_data <= next_rd_word;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      status_sel <= STATUS_SEL_RST;
      fb_ctrl <= FB_CTRL_RST;
      swallow <= SWALLOW_RST;
      main_cnt <= MAIN_CNT_RST;
      ref_div <= REF_DIV_RST;
      diff_mode <= INPUT_CFG_RST;
    end else begin
      status_sel <= next_status_sel;
      fb_ctrl <= next_fb_ctrl;
      swallow <= next_swallow;
      main_cnt <= next_main_cnt;
      ref_div <= next_ref_div;
      diff_mode <= next_diff_mode;
    end
  end

  // Control fields.
  wire hold_all = fb_ctrl[RESET_ALL_BIT];
  wire bypass = fb_ctrl[BYPASS_BIT];
  wire [PRESC_W-1:0] presc_code = fb_ctrl[PRESC_W-1:0];
  wire [SEL_W-1:0] sel_code = status_sel[SEL_LSB +: SEL_W];

  // Feedback path: prescaler, swallow and main counters.
  wire presc_pulse;
  wire swallow_pulse;
  wire fb_pulse;

  feedback_divider #(
    .SW_W(SWALLOW_W),
    .MN_W(MAIN_W)
  ) u_feedback (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .tick_i(fb_tick),
    .hold_i(hold_all),
    .presc_code_i(presc_code),
    .bypass_i(bypass),
    .swallow_i(swallow),
    .main_i(main_cnt),
    .presc_pulse_o(presc_pulse),
    .swallow_pulse_o(swallow_pulse),
    .fb_pulse_o(fb_pulse)
  );

  // Reference divider; a ratio of zero behaves as one.
  wire [REF_W-1:0] ref_limit = (ref_div == '0) ? REF_W'(1) : ref_div;
  wire ref_end = ref_cnt >= (ref_limit - REF_W'(1));
  wire ref_pulse = ref_tick && ref_end && !hold_all;

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ref_cnt <= '0;
    end else if (hold_all) begin
      ref_cnt <= '0;
    end else if (ref_tick) begin
      ref_cnt <= ref_end ? '0 : ref_cnt + REF_W'(1);
    end
  end

  // Status pin multiplexer.
  wire status_next;

  status_select u_status (
    .sel_i(sel_code),
    .diff_i(diff_mode),
    .fb_div_i(fb_q),
    .ref_div_i(ref_q),
    .swallow_i(swallow_q),
    .presc_i(presc_q),
    .det_up_i(pin_sync[P_UP]),
    .det_down_i(pin_sync[P_DN]),
    .first_clk_i(r1_s),
    .second_clk_i(r2_s),
    .ref_sel_i(rsel_s),
    .first_ok_i(r1ok_s),
    .second_ok_i(r2ok_s),
    .vco_ok_i(vco_s),
    .dig_lock_i(dlk_s),
    .holdover_i(hold_s),
    .lock_cmp_i(pin_sync[P_CMP]),
    .supply_i(pin_sync[P_SUP]),
    .status_o(status_next)
  );

  // Registered pins so no decode glitch reaches the board.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      fb_q <= 1'b0;
      ref_q <= 1'b0;
      swallow_q <= 1'b0;
      presc_q <= 1'b0;
      status_q <= 1'b0;
    end else begin
      fb_q <= fb_pulse;
      ref_q <= ref_pulse;
      swallow_q <= swallow_pulse;
      presc_q <= presc_pulse;
      status_q <= status_next;
    end
  end

  assign STATUS_O = status_q;
  assign FEEDBACK_DIV_O = fb_q;
  assign REF_DIV_O = ref_q;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // A whole-word write to the selector register in its address phase.
  sequence s_sel_write;
    addr_phase && HWRITE_I && addr_mapped && addr_idx == IDX_STATUS_SEL;
  endsequence

  // The data phase carrying the holdover code.
  sequence s_holdover_data;
    HWDATA_I[7:2] == SEL_HOLDOVER;
  endsequence

  a_holdover_route: assert property (
    s_sel_write ##1 s_holdover_data |=> sel_code == SEL_HOLDOVER ##1 STATUS_O == $past(hold_s))
    else $error("holdover level not routed after selector write");

  a_low_ground: assert property (
    (!sel_code[5] && (sel_code == SEL_GROUND || sel_code > SEL_DET_DOWN)) |=> !STATUS_O)
    else $error("unused low selector code did not ground the pin");

  a_monitor_ground: assert property (
    (sel_code == SEL_MON_GROUND) |=> !STATUS_O)
    else $error("monitor ground code drove the pin");

  a_dig_lock: assert property (
    (sel_code == SEL_DIG_LOCK) |=> STATUS_O == $past(dlk_s))
    else $error("lock flag not routed");

  a_lock_and: assert property (
    (sel_code == SEL_LOCK_AND) |=>
      STATUS_O == $past(dlk_s && (use_second ? r2ok_s : r1ok_s) && vco_s))
    else $error("lock AND not routed");

  a_ref_in_use: assert property (
    (sel_code == SEL_REF_IN_USE) |=> STATUS_O == $past(rsel_s))
    else $error("reference selection level not routed");

  a_counters_held: assert property (
    hold_all [*2] |-> ref_cnt == '0 && !REF_DIV_O && !FEEDBACK_DIV_O)
    else $error("counters ran while held in reset");

  a_fb_tap: assert property (
    (sel_code == SEL_FB_DIV) |=> STATUS_O == $past(fb_q))
    else $error("feedback tap not routed");

endmodule : pll_divider_status_select

/* File: test/status_monitor.sv */
`timescale 1ns/10ps
// Board-side monitor that reads the status pin as a plain level.
module status_monitor (
  // Clock and pin.
  input wire logic clk_i,
  input wire logic status_i,
  // Level seen by the board.
  output logic level_o
);
  // The board samples the pin through its own flop, one clock late.
  always_ff @(posedge clk_i) begin
    level_o <= status_i;
  end
endmodule : status_monitor

/* File: test/pll_divider_status_select_test.sv */
`timescale 1ns/10ps
module pll_divider_status_select_test;
  import pll_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic fb = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [11:0] lv = 12'h000;
  logic [31:0] hrdata;
  logic hready, hresp, st, fbo, mon, rdo;
  int errors = 0;
  int checks_done = 0;
  int pulses = 0;
  int rpulses = 0;
  int spulses = 0;

  // Free-running clock of 100 ns; count divider pulses and status pulses seen by the board.
  always #50 clk = ~clk;
  always @(posedge clk) if (fbo === 1'b1) pulses++;
  always @(posedge clk) if (rdo === 1'b1) rpulses++;
  always @(posedge clk) if (mon === 1'b1) spulses++;

  // The one slave's ready is the bus ready.
  pll_divider_status_select uut (.CLK_I(clk), .RESET_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(HSIZE_WORD),
    .HREADY_I(hready), .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .FEEDBACK_CLK_I(fb), .FIRST_REFERENCE_INPUT_I(lv[0]),
    .SECOND_REFERENCE_INPUT_I(lv[1]), .PHASE_FREQ_DETECTOR_UP_I(lv[2]),
    .PHASE_FREQ_DETECTOR_DOWN_I(lv[3]), .REF_SELECT_I(lv[4]), .FIRST_REF_FREQ_OK_I(lv[5]),
    .SECOND_REF_FREQ_OK_I(lv[6]), .VCO_FREQ_OK_I(lv[7]), .DIGITAL_LOCK_FLAG_I(lv[8]),
    .HOLDOVER_I(lv[9]), .LOCK_DETECT_PIN_CMP_I(lv[10]), .PLL_SUPPLY_LEVEL_I(lv[11]),
    .STATUS_O(st), .FEEDBACK_DIV_O(fbo), .REF_DIV_O(rdo));
  status_monitor board (.clk_i(clk), .status_i(st), .level_o(mon));

  // Compare and report.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Address phase is held until ready is sampled high.
  task automatic addr(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
  endtask : addr

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    addr(a, 1'b1);
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    addr(a, 1'b0);
    do @(posedge clk); while (hready !== 1'b1);
    check("read", hrdata, exp);
  endtask : rd

  // Feedback and first reference edges, each level held two clocks for the synchroniser.
  task automatic edges(input int n);
    repeat (n) begin
      fb <= 1'b1;
      lv[0] <= 1'b1;
      repeat (2) @(posedge clk);
      fb <= 1'b0;
      lv[0] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : edges

  // Expected pin level; patterns keep reference select low in differential mode.
  function automatic logic exp_st(input logic [5:0] c, input logic [11:0] v, input logic d);
    case (c)
      6'h05: return v[2];
      6'h06: return v[3];
      6'h21: return v[0];
      6'h22: return v[1] & ~d;
      6'h23: return v[4] ? v[1] : v[0];
      6'h24: return ~d & (v[4] ? v[0] : v[1]);
      6'h25: return v[4] ? v[6] : v[5];
      6'h26: return ~d & (v[4] ? v[5] : v[6]);
      6'h27: return v[5];
      6'h28: return v[6];
      6'h29: return v[5] & v[6];
      6'h2A: return v[8] & v[7] & (v[4] ? v[6] : v[5]);
      6'h2B: return v[7];
      6'h2C: return v[4];
      6'h2D: return v[8];
      6'h2E: return v[9];
      6'h2F: return v[10];
      6'h30: return v[11];
      default: return 1'b0;
    endcase
  endfunction : exp_st

  // Feedback divide for a control value, swallow a and main count b.
  function automatic int ratio(input logic [3:0] ctl, input int a, input int b);
    int p [8] = '{1, 2, 2, 4, 8, 16, 32, 3};
    if (ctl[2:0] inside {[2:6]}) return p[ctl[2:0]] * b + a;
    return ctl[3] ? p[ctl[2:0]] : p[ctl[2:0]] * b;
  endfunction : ratio

  task automatic results;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // Watchdog sized well above the expected run of some ten thousand clocks.
  initial begin
    #3_000_000;
    errors++;
    results;
  end

  // Main sequence.
  initial begin
    static logic [11:0] pat [4] = '{12'hA5A, 12'h5A5, 12'hFFF, 12'h3C3};
    logic e;
    int n;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'h0000_001C, 32'h0000_0000);
    rd(32'h0000_0058, 32'h0000_0000);
    rd(32'h0000_00C4, 32'h0000_0001);
    rd(32'h0000_00C8, 32'h0000_0001);
    wr(32'h0000_00FC, 32'hFFFF_FFFF);
    rd(32'h0000_00FC, 32'h0000_0000);
    wr(32'h0000_001C, 32'h0000_00B9);
    rd(32'h0000_001C, 32'h0000_00B9);
    check("resp", {31'h0, hresp}, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      lv <= pat[i];
      wr(32'h0000_00CC, i % 2);
      for (int c = 0; c < 64; c++) begin
        if (c inside {[1:4]}) continue;
        wr(32'h0000_001C, c * 4);
        repeat (5) @(posedge clk);
        e = exp_st(c[5:0], pat[i], i % 2);
        if (c < 32) check("status", mon, e);
        else if (c < 37) check("status", mon, e);
        else if (c < 43) check("status", mon, e);
        else check("status", mon, e);
      end
    end
    // Quiet pins first, so the first reference starts low and every edge counts.
    lv <= 12'h000;
    wr(32'h0000_0058, 32'h0000_0010);
    pulses = 0;
    rpulses = 0;
    edges(8);
    repeat (6) @(posedge clk);
    check("held", pulses, 0);
    check("ref held", rpulses, 0);
    rd(32'h0000_00D0, 32'h0000_0002);
    wr(32'h0000_00C4, 32'h0000_0002);
    wr(32'h0000_001C, 32'h0000_0004);
    for (int a = 0; a < 2; a++) begin
      wr(32'h0000_00C0, a);
      for (int ctl = 0; ctl < 16; ctl++) begin
        wr(32'h0000_0058, ctl + 16);
        wr(32'h0000_0058, ctl);
        n = 3 * ratio(ctl[3:0], a, 2);
        pulses = 0;
        rpulses = 0;
        spulses = 0;
        edges(n);
        repeat (6) @(posedge clk);
        if (ctl % 8 < 4) check("fb", pulses, 3);
        else check("fb", pulses, 3);
        check("ref", rpulses, n);
        check("fb tap", spulses, 3);
      end
    end
    results;
  end
endmodule : pll_divider_status_select_test
